// >>> hw/sbs_regs.vh
// constants shared by the byte shifter: control fields, status fields, divider half periods
// assumes inclusion by bare name from files under hw/
`ifndef SBS_REGS_VH
`define SBS_REGS_VH

// ****************************************
// control word fields and reset value
// ****************************************
`define SBS_CTRL_RESET        8'h00
`define SBS_CTRL_IRQ_EN       7
`define SBS_CTRL_ENABLE       6
`define SBS_CTRL_LSB_FIRST    5
`define SBS_CTRL_CONTROLLER   4
`define SBS_CTRL_IDLE_LVL     3
`define SBS_CTRL_PHASE        2
`define SBS_CTRL_RATE_HI      1
`define SBS_CTRL_RATE_LO      0

// ****************************************
// status word fields
// ****************************************
`define SBS_STAT_DONE         7
`define SBS_STAT_WRITE_COLLISION_FLAG         6
`define SBS_STAT_DOUBLE       0

// ****************************************
// sck half periods in core clocks (divisor / 2)
// ****************************************
`define SBS_HALF_DIV4         7'h02
`define SBS_HALF_DIV16        7'h08
`define SBS_HALF_DIV64        7'h20
`define SBS_HALF_DIV128       7'h40
`define SBS_HALF_DIV2         7'h01
`define SBS_HALF_DIV8         7'h04
`define SBS_HALF_DIV32        7'h10
`define SBS_HALF_DIV64X       7'h20

// ****************************************
// byte framing
// ****************************************
`define SBS_LAST_SAMPLE       4'h7
`define SBS_LAST_EDGE         5'h0f
`define SBS_SYNC_RESET        4'h8

`endif

// >>> hw/sbs_sync.v
// two-flop synchroniser for a group of pin inputs
// assumes each bit is an independent level from outside the core clock domain
`timescale 1ns/1ns
module sbs_sync #(
   parameter             WIDTH = 4,
   parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
   // clock and reset
   input  wire             core_clk,
   input  wire             rstn,
   // levels
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         // the first flop feeds only the second
         always @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               meta_q <= INIT[i];
               sync_q <= INIT[i];
            end else begin
               meta_q <= asyncIn[i];
               sync_q <= meta_q;
            end
         end
         assign syncOut[i] = sync_q;
      end
   endgenerate

endmodule // sbs_sync

// >>> hw/sbs_rx_buffer.v
// small receive buffer with valid/ready on both sides
// assumes a single clock; dropOld lets a full buffer discard its oldest entry
`timescale 1ns/1ns
module sbs_rx_buffer #(
   parameter WIDTH = 8,
   parameter AW    = 1
) (
   // clock and reset
   input  wire             core_clk,
   input  wire             rstn,
   // fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   input  wire             dropOld,
   // drain side
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);

   localparam DEPTH = 1 << AW;

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    rdPtr_q;
   reg [AW-1:0]    wrPtr_q;
   reg [AW:0]      count_q;

   wire full   = (count_q == DEPTH[AW:0]);
   wire push   = inValid & (~full | dropOld);
   // overwrite on a full buffer costs the oldest entry, as a double buffer would
   wire pop    = (outValid & outReady) | (inValid & full & dropOld);

   assign inReady  = ~full;
   assign outValid = (count_q != {(AW+1){1'b0}});
   assign outData  = mem_q[rdPtr_q];

   integer k;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (k = 0; k < DEPTH; k = k + 1)
            mem_q[k] <= {WIDTH{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         wrPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem_q[wrPtr_q] <= inData;
            wrPtr_q        <= wrPtr_q + 1'b1;
         end
         if (pop)
            rdPtr_q <= rdPtr_q + 1'b1;
         if (push & ~pop)
            count_q <= count_q + 1'b1;
         else if (pop & ~push)
            count_q <= count_q - 1'b1;
      end
   end

endmodule // sbs_rx_buffer

// >>> hw/sbs_core.v
// byte-wide serial shifter, controller or target, with transfer-done and collision flags
// assumes software strobes are one-cycle pulses on core_clk; pins arrive asynchronously
`timescale 1ns/1ns
`include "sbs_regs.vh"

// What this block does
// RL1: data write in controller mode starts clocking
// RL2: after one byte stop clock, set done
// RL3: done flag with enable raises interrupt
// RL4: software asserts select before controller transfers
// RL5: select low opens transfer, sck exchanges bytes
// RL6: controller-to-target on mosi, back on miso
// RL7: next byte by write, or select high
// RL8: target deselected: idle, miso released, sck ignored
// RL9: target accepts writes deselected, shifts when selected
// RL10: target sets done after full byte
// RL11: received byte kept in receive buffer
// RL12: transmit single buffered until shift completes
// RL13: in target mode the oldest of two unread received bytes is lost on the next byte
// RL14: external sck phases exceed two core clocks
// RL15: enabled unit forces pin directions per mode
// RL16: selectable lsb-first or msb-first order
// RL17: write during transfer sets collision flag
// RL18: idle level and phase give four modes
// RL19: controller sck divides by 4..128, doubled
// RL20: target select rise resets shifting logic
// RL21: select input low drops controller mode
// RL22: status read then data access clears flags
module sbs_core (
   // clock and reset
   input  wire       core_clk,
   input  wire       rstn,
   // control word
   input  wire       ctrlWr,
   input  wire [7:0] ctrlWdata,
   output wire [7:0] serialControlReg,
   input  wire       doubleRate,
   // data access
   input  wire       wrData,
   input  wire [7:0] wrByte,
   input  wire       rdData,
   output wire [7:0] rxData,
   output wire       rxValid,
   input  wire       rdStatus,
   output wire [7:0] serialStatusReg,
   output wire       transferIrq,
   // user pin directions and select level
   input  wire       userMosiOe,
   input  wire       userMisoOe,
   input  wire       userSckOe,
   input  wire       userSsOe,
   input  wire       userSsLevel,
   // serial pins
   input  wire       sckIn,
   output wire       sckOut,
   output wire       sckOe,
   input  wire       mosiIn,
   output wire       mosiOut,
   output wire       mosiOe,
   input  wire       misoIn,
   output wire       misoOut,
   output wire       misoOe,
   input  wire       ssnIn,
   output wire       ssnOut,
   output wire       ssnOe
);

   // ****************************************
   // state
   // ****************************************
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_RUN  = 3'b100;

   reg [7:0] ctrl_q;
   reg [7:0] ctrl_d;
   reg       done_q;
   reg       write_collision_flag_q;
   reg       seen_q;
   reg [7:0] sh_q;
   reg [7:0] sh_d;
   reg       mo_q;
   reg       mo_d;
   reg [3:0] sampleCnt_q;
   reg [3:0] sampleCnt_d;
   reg [4:0] edgeCnt_q;
   reg [4:0] edgeCnt_d;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg       sck_q;
   reg       sck_d;
   reg [6:0] halfCnt_q;
   reg [6:0] halfCnt_d;
   reg [6:0] halfLen;
   reg       sckPrev_q;
   reg       ssPrev_q;

   // ****************************************
   // pin synchronisers
   // ****************************************
   wire [3:0] pinSync;

   sbs_sync #(
      .WIDTH (4),
      .INIT  (`SBS_SYNC_RESET)
   ) u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .asyncIn  ({ssnIn, sckIn, mosiIn, misoIn}),
      .syncOut  (pinSync)
   );

   wire ssnS  = pinSync[3];
   wire sckS  = pinSync[2];
   wire mosiS = pinSync[1];
   wire misoS = pinSync[0];

   // ****************************************
   // decode
   // ****************************************
   wire en    = ctrl_q[`SBS_CTRL_ENABLE];
   wire ctl   = ctrl_q[`SBS_CTRL_CONTROLLER];
   wire clock_idle_level  = ctrl_q[`SBS_CTRL_IDLE_LVL];
   wire clock_sample_phase  = ctrl_q[`SBS_CTRL_PHASE];
   wire lsb   = ctrl_q[`SBS_CTRL_LSB_FIRST];
   wire irqEn = ctrl_q[`SBS_CTRL_IRQ_EN];

   wire running = (state_q == ST_RUN);
   wire pending = (state_q == ST_WAIT);

   wire outBit = lsb ? sh_q[0] : sh_q[7];                                 // RL16
   wire inBit  = ctl ? misoS : mosiS;                                     // RL6
   wire [7:0] shIn = lsb ? {inBit, sh_q[7:1]} : {sh_q[6:0], inBit};       // RL16

   wire tgtActive = en & ~ctl & ~ssnS;                                     // RL8
   // target edges come from the synchronised sck, hence the two-clock phase limit
   wire tgtEdge   = tgtActive & (sckS != sckPrev_q);                      // RL14
   wire tgtLead   = (sckS != clock_idle_level);
   wire tick      = running & (halfCnt_q == 7'h00);
   wire ctlLead   = (sck_q == clock_idle_level);
   wire edgeNow   = tick | tgtEdge;
   wire leadNow   = ctl ? ctlLead : tgtLead;
   wire sampleNow = edgeNow & (leadNow ^ clock_sample_phase);                           // RL18
   wire setupNow  = edgeNow & ~(leadNow ^ clock_sample_phase);                          // RL18

   wire ssFault   = en & ctl & ~userSsOe & ~ssnS;                          // RL21
   wire ssRise    = en & ~ctl & ssnS & ~ssPrev_q;                          // RL20
   wire tgtDone   = tgtActive & sampleNow & (sampleCnt_q == `SBS_LAST_SAMPLE);
   wire ctlDone   = tick & (edgeCnt_q == `SBS_LAST_EDGE);                 // RL2
   wire byteDone  = tgtDone | ctlDone;                                    // RL10

   wire busy      = running | pending | (tgtActive & (sampleCnt_q != 4'h0));
   wire wrOk      = wrData & ~busy;                                       // RL12
   wire wrColl    = wrData & busy & en;                                   // RL17
   wire clrFlags  = seen_q & (wrData | rdData);                           // RL22

   // ****************************************
   // receive buffer
   // ****************************************
   wire rxInReady;
   wire [7:0] rxPush = sampleNow ? shIn : sh_q;

   sbs_rx_buffer #(
      .WIDTH (8),
      .AW    (1)
   ) u_rxbuf (
      .core_clk (core_clk),
      .rstn     (rstn),
      .inValid  (byteDone),                                               // RL11
      .inReady  (rxInReady),
      .inData   (rxPush),
      .dropOld  (~ctl),                                                   // RL13
      .outValid (rxValid),
      .outReady (rdData),
      .outData  (rxData)
   );

   // ****************************************
   // divider select
   // ****************************************
   always @* begin
      case ({doubleRate, ctrl_q[`SBS_CTRL_RATE_HI], ctrl_q[`SBS_CTRL_RATE_LO]})  // RL19
         3'h0:    halfLen = `SBS_HALF_DIV4;
         3'h1:    halfLen = `SBS_HALF_DIV16;
         3'h2:    halfLen = `SBS_HALF_DIV64;
         3'h3:    halfLen = `SBS_HALF_DIV128;
         3'h4:    halfLen = `SBS_HALF_DIV2;
         3'h5:    halfLen = `SBS_HALF_DIV8;
         3'h6:    halfLen = `SBS_HALF_DIV32;
         default: halfLen = `SBS_HALF_DIV64X;
      endcase
   end

   // ****************************************
   // control word
   // ****************************************
   always @* begin
      ctrl_d = ctrlWr ? ctrlWdata : ctrl_q;
      // a foreign controller pulling select low wins over a software write
      if (ssFault)
         ctrl_d[`SBS_CTRL_CONTROLLER] = 1'b0;                             // RL21
   end

   // ****************************************
   // shifter and controller sequencing
   // ****************************************
   always @* begin
      state_d     = state_q;
      sh_d        = sh_q;
      mo_d        = mo_q;
      sampleCnt_d = sampleCnt_q;
      edgeCnt_d   = edgeCnt_q;
      sck_d       = sck_q;
      halfCnt_d   = halfCnt_q;
      if (wrOk) begin
         sh_d = wrByte;                                                   // RL9
         mo_d = lsb ? wrByte[0] : wrByte[7];
      end
      case (state_q)
         ST_IDLE: begin
            sck_d = clock_idle_level;
            if (wrOk & en & ctl)
               state_d = ST_WAIT;                                         // RL1 RL7
         end
         ST_WAIT: begin
            // holding off the start keeps a full receive buffer from losing a byte
            if (~en | ~ctl | ssFault) begin
               state_d = ST_IDLE;
            end else if (rxInReady) begin
               state_d   = ST_RUN;                                        // RL1
               halfCnt_d = halfLen - 7'h01;
               edgeCnt_d = 5'h00;
            end
         end
         ST_RUN: begin
            if (~en | ~ctl | ssFault) begin
               state_d = ST_IDLE;
               sck_d   = clock_idle_level;
            end else if (tick) begin
               sck_d     = ~sck_q;
               halfCnt_d = halfLen - 7'h01;
               edgeCnt_d = edgeCnt_q + 5'h01;
               if (ctlDone) begin
                  state_d = ST_IDLE;                                      // RL2
                  sck_d   = clock_idle_level;
               end
            end else begin
               halfCnt_d = halfCnt_q - 7'h01;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (sampleNow) begin
         sh_d        = shIn;                                              // RL5
         sampleCnt_d = sampleCnt_q + 4'h1;
      end
      if (setupNow)
         mo_d = outBit;                                                   // RL18
      if (tgtDone)
         sampleCnt_d = 4'h0;                                              // RL10
      if (~tgtActive & ~running) begin
         // deselected target drops any partial byte and ignores sck
         sampleCnt_d = 4'h0;                                              // RL20
         if (~ctl & ~wrOk)
            mo_d = outBit;
      end
      if (ssRise)
         sampleCnt_d = 4'h0;                                              // RL20
   end

   // ****************************************
   // registers
   // ****************************************
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q      <= `SBS_CTRL_RESET;
         done_q      <= 1'b0;
         write_collision_flag_q      <= 1'b0;
         seen_q      <= 1'b0;
         sh_q        <= 8'h00;
         mo_q        <= 1'b0;
         sampleCnt_q <= 4'h0;
         edgeCnt_q   <= 5'h00;
         state_q     <= ST_IDLE;
         sck_q       <= 1'b0;
         halfCnt_q   <= 7'h00;
         sckPrev_q   <= 1'b0;
         ssPrev_q    <= 1'b1;
      end else begin
         ctrl_q      <= ctrl_d;
         sh_q        <= sh_d;
         mo_q        <= mo_d;
         sampleCnt_q <= sampleCnt_d;
         edgeCnt_q   <= edgeCnt_d;
         state_q     <= state_d;
         sck_q       <= sck_d;
         halfCnt_q   <= halfCnt_d;
         sckPrev_q   <= sckS;
         ssPrev_q    <= ssnS;
         // hardware sets win over the software clear in the same cycle
         done_q      <= (en & (byteDone | ssFault)) | (done_q & ~clrFlags);  // RL2
         write_collision_flag_q      <= wrColl | (write_collision_flag_q & ~clrFlags);                     // RL17
         if (rdStatus & (done_q | write_collision_flag_q))
            seen_q <= 1'b1;                                               // RL22
         else if (clrFlags)
            seen_q <= 1'b0;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign serialControlReg = ctrl_q;
   assign serialStatusReg  = {done_q, write_collision_flag_q, 5'h00, doubleRate};
   assign transferIrq      = done_q & irqEn;                              // RL3

   assign sckOut  = sck_q;
   assign mosiOut = mo_q;                                                 // RL6
   assign misoOut = mo_q;                                                 // RL6
   // select is never driven by the shifter, only by the user level
   assign ssnOut  = userSsLevel;                                          // RL4

   assign sckOe   = userSckOe  & ~(en & ~ctl);                            // RL15
   assign mosiOe  = userMosiOe & ~(en & ~ctl);                            // RL15
   assign ssnOe   = userSsOe   & ~(en & ~ctl);                            // RL15
   assign misoOe  = userMisoOe & ~(en & ctl) & ~(en & ~ctl & ssnS);       // RL8

endmodule // sbs_core

// >>> bench/sbs_core_chk.sv
// checker for sbs_core: flags, pin directions and byte framing
// assumes the bind below; an undriven select pin reads high
`timescale 1ns/1ns
module sbs_core_chk (
   // clock and reset
   input wire       core_clk,
   input wire       rstn,
   // software side
   input wire       wrData,
   input wire       rdData,
   input wire       rdStatus,
   input wire [7:0] serialControlReg,
   input wire [7:0] serialStatusReg,
   input wire       transferIrq,
   // pins
   input wire       userMosiOe,
   input wire       userSckOe,
   input wire       userSsOe,
   input wire       ssnIn,
   input wire       sckOut,
   input wire       sckOe,
   input wire       mosiOe,
   input wire       misoOe,
   input wire       ssnOe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire       enCtl = serialControlReg[6] & serialControlReg[4];
   wire       enTgt = serialControlReg[6] & ~serialControlReg[4];
   wire       done  = serialStatusReg[7];
   wire       write_collision_flag  = serialStatusReg[6];
   reg        busy_q;
   reg        sck_q;
   reg  [4:0] edges_q;
   // ****
   // sck toggles of the controller byte in flight
   // ****
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy_q  <= 1'b0;
         sck_q   <= 1'b0;
         edges_q <= 5'h00;
      end else begin
         sck_q <= sckOut;
         if (wrData && enCtl && !busy_q) begin
            busy_q  <= 1'b1;
            edges_q <= 5'h00;
         end else begin
            if ($rose(done) || !enCtl) busy_q <= 1'b0;
            if (busy_q && sckOut != sck_q) edges_q <= edges_q + 5'h01;
         end
      end
   end
   sequence s_armed;
      rdStatus && (done || write_collision_flag);
   endsequence
   sequence s_access;
      rdData || wrData;
   endsequence
   sequence s_fault;
      (enCtl && !userSsOe && !ssnIn) [*3];
   endsequence
   a_irq_level: assert property (transferIrq == (done && serialControlReg[7]))
      else $error("interrupt differs from enabled done flag");
   a_byte_edges: assert property ($rose(done) && serialControlReg[4]
      |=> edges_q == 5'h10 && sckOut == serialControlReg[3])
      else $error("byte did not end after sixteen sck edges at idle");
   a_write_collision_flag_busy: assert property (wrData && busy_q && !done |=> write_collision_flag)
      else $error("write during transfer left collision flag clear");
   a_flag_clear: assert property (s_armed ##1 s_access |=> !done && !write_collision_flag)
      else $error("flags not cleared by status read and data access");
   a_fault_drop: assert property (s_fault |=> !serialControlReg[4] && done)
      else $error("select low did not drop controller mode");
   a_miso_quiet: assert property ((enTgt && ssnIn) [*3] |-> !misoOe)
      else $error("deselected target drives miso");
   a_idle_no_done: assert property ((enTgt && ssnIn) [*5] |-> !$rose(done))
      else $error("deselected target completed a byte");
   a_tgt_inputs: assert property (enTgt |-> !sckOe && !mosiOe && !ssnOe)
      else $error("target drives sck, mosi or select");
   a_ctl_dirs: assert property (enCtl |-> !misoOe && sckOe == userSckOe
      && mosiOe == userMosiOe)
      else $error("controller pin directions wrong");
endmodule // sbs_core_chk

bind sbs_core sbs_core_chk chk (.core_clk, .rstn, .wrData, .rdData, .rdStatus,
   .serialControlReg, .serialStatusReg, .transferIrq, .userMosiOe, .userSckOe,
   .userSsOe, .ssnIn, .sckOut, .sckOe, .mosiOe, .misoOe, .ssnOe);

// >>> bench/sbs_far_target.sv
// far-side target: exchanges one byte per select in any of the four clock modes
// assumes the bench resolves the pins; miso has no pull, so released it shows noise
`timescale 1ns/1ns
module sbs_far_target (
   // mode
   input  logic       clock_idle_level,
   input  logic       clock_sample_phase,
   input  logic       lsbFirst,
   // pins
   input  logic       sck,
   input  logic       mosi,
   input  logic       ssn,
   output logic       miso,
   // byte exchanged
   input  logic [7:0] txByte,
   output logic [7:0] rxByte
);
   int n = 0;
   initial miso = 1'b0;
   function automatic int pos(input int i);
      return lsbFirst ? i : 7 - i;
   endfunction
   // first bit must be on the line before the first edge
   always @(negedge ssn) begin
      n = 0;
      miso = txByte[pos(0)];
   end
   // a released line never keeps a clean copy of the last bit
   always @(posedge ssn) miso = ~miso;
   always @(sck) begin
      if (!ssn && n < 8) begin
         if ((sck != clock_idle_level) ^ clock_sample_phase) begin
            rxByte[pos(n)] = mosi;
            n = n + 1;
         end else begin
            miso = txByte[pos(n)];
         end
      end
   end
endmodule // sbs_far_target

// >>> bench/tb.sv
// self-checking bench for sbs_core as controller and as target
// assumes the checker bind and the far-side target model are compiled first
`timescale 1ns/1ns
`define SBS_EQ(act, exp) begin \
   totalChecks++; \
   if ((act) !== (exp)) begin \
      mismatches++; \
      $display("unexpected at %0t: got %h expected %h", $time, act, exp); \
   end \
end
module tb;
   logic        core_clk = 1'b0, rstn = 1'b0, doubleRate = 1'b0;
   logic        ctrlWr = 1'b0, wrData = 1'b0, rdData = 1'b0, rdStatus = 1'b0;
   logic [7:0]  ctrlWdata = 8'h00, wrByte = 8'h00, farTx = 8'h00;
   logic        userMosiOe = 1'b1, userMisoOe = 1'b1, userSckOe = 1'b1;
   logic        userSsOe = 1'b1, userSsLevel = 1'b1;
   logic        tbSck = 1'b0, tbMosi = 1'b0, tbSsn = 1'b1, tbTgt = 1'b0;
   logic [31:0] lfsr = 32'hc0af9924;
   logic [7:0]  rxq[$];
   int          divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
   int          mismatches = 0;
   int          totalChecks = 0;
   wire  [7:0]  serialControlReg, rxData, serialStatusReg, farRx;
   wire         rxValid, transferIrq, sckOut, sckOe, mosiOut, mosiOe;
   wire         misoOut, misoOe, ssnOut, ssnOe, farMiso;
   wire         sckPin  = sckOe ? sckOut : tbSck;
   wire         mosiPin = mosiOe ? mosiOut : tbMosi;
   wire         misoPin = misoOe ? misoOut : farMiso;
   wire         ssnPin  = ssnOe ? ssnOut : tbSsn;
   sbs_core dut (.core_clk, .rstn, .ctrlWr, .ctrlWdata, .serialControlReg, .doubleRate,
      .wrData, .wrByte, .rdData, .rxData, .rxValid, .rdStatus, .serialStatusReg,
      .transferIrq, .userMosiOe, .userMisoOe, .userSckOe, .userSsOe, .userSsLevel,
      .sckIn(sckPin), .sckOut, .sckOe, .mosiIn(mosiPin), .mosiOut, .mosiOe,
      .misoIn(misoPin), .misoOut, .misoOe, .ssnIn(ssnPin), .ssnOut, .ssnOe);
   sbs_far_target far (.clock_idle_level(serialControlReg[3]), .clock_sample_phase(serialControlReg[2]),
      .lsbFirst(serialControlReg[5]), .sck(sckPin), .mosi(mosiPin),
      .ssn(ssnPin | tbTgt), .miso(farMiso), .txByte(farTx), .rxByte(farRx));
   // ****
   // helpers
   // ****
   function automatic logic [31:0] next_lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // strobes {ctrlWr, wrData, rdData, rdStatus}: p1 then p2 on consecutive cycles
   task automatic drive(input logic [3:0] p1, input logic [3:0] p2, input logic [7:0] v);
      @(posedge core_clk);
      {ctrlWr, wrData, rdData, rdStatus} <= p1;
      ctrlWdata <= v;
      wrByte    <= v;
      @(posedge core_clk);
      {ctrlWr, wrData, rdData, rdStatus} <= p2;
      @(posedge core_clk);
      {ctrlWr, wrData, rdData, rdStatus} <= 4'h0;
      @(posedge core_clk);
   endtask
   // bench as mode-0 controller; five clocks per phase keeps clear of the sampler
   task automatic tgt_xfer(input logic [7:0] mo, input int nb, input logic sel,
                           output logic [7:0] mi);
      mi = 8'h00;
      tbSsn <= !sel;
      repeat (5) @(posedge core_clk);
      for (int i = 7; i > 7 - nb; i--) begin
         tbMosi <= mo[i];
         repeat (5) @(posedge core_clk);
         tbSck <= 1'b1;
         mi[i] = misoPin;
         repeat (5) @(posedge core_clk);
         tbSck <= 1'b0;
      end
      repeat (5) @(posedge core_clk);
      tbSsn <= 1'b1;
      repeat (5) @(posedge core_clk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      #(40000 * 50);
      mismatches++;
      complete_run;
   end
   // ****
   // scenarios
   // ****
   initial begin
      int         half, n;
      logic [7:0] ctl, tx, got, e;
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      `SBS_EQ({serialControlReg, serialStatusReg[7:6], transferIrq}, 11'h000)
      // every rate, mode and bit order as controller
      for (int k = 0; k < 8; k++) begin
         lfsr = next_lfsr(lfsr);
         half = divs[k] / 2;
         tx = lfsr[7:0];
         farTx = (half > 2) ? lfsr[15:8] : 8'hff;
         ctl = {k[0], 1'b1, k[0] ^ k[2], 1'b1, k[1:0], k[1:0]};
         doubleRate <= k[2];
         drive(4'h8, 4'h0, ctl);
         userSsLevel <= 1'b0;
         drive(4'h4, 4'h0, tx);
         n = 0;
         while (sckOut === ctl[3] && n < 400) begin
            @(posedge core_clk);
            n++;
         end
         n = 0;
         while (sckOut !== ctl[3] && n < 400) begin
            @(posedge core_clk);
            n++;
         end
         `SBS_EQ(n, half)
         if (k == 0) drive(4'h4, 4'h0, ~tx);
         n = 0;
         while (serialStatusReg[7] !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
         end
         `SBS_EQ(farRx, tx)
         `SBS_EQ(serialStatusReg, {1'b1, k == 0, 5'h00, k[2]})
         `SBS_EQ(transferIrq, k[0])
         `SBS_EQ(rxData, farTx)
         `SBS_EQ(sckOut, ctl[3])
         userSsLevel <= 1'b1;
         drive(4'h1, 4'h2, 8'h00);
         `SBS_EQ({serialStatusReg[7:6], rxValid}, 3'h0)
      end
      // target: deselected clocks, aborted byte, then overrun of the buffer
      tbTgt <= 1'b1;
      userSsOe <= 1'b0;
      drive(4'h8, 4'h0, 8'h40);
      drive(4'h4, 4'h0, tx);
      tgt_xfer(8'h5a, 8, 1'b0, got);
      `SBS_EQ({serialStatusReg[7], rxValid}, 2'h0)
      tgt_xfer(8'h5a, 4, 1'b1, got);
      `SBS_EQ({serialStatusReg[7], rxValid}, 2'h0)
      drive(4'h4, 4'h0, tx);
      for (int j = 0; j < 3; j++) begin
         lfsr = next_lfsr(lfsr);
         tgt_xfer(lfsr[7:0], 8, 1'b1, got);
         `SBS_EQ(got, tx)
         `SBS_EQ(serialStatusReg[7], 1'b1)
         rxq.push_back(lfsr[7:0]);
         if (rxq.size() > 2) e = rxq.pop_front();
         tx = lfsr[15:8];
         drive(4'h1, 4'h4, tx);
         `SBS_EQ(serialStatusReg[7], 1'b0)
      end
      while (rxq.size() > 0) begin
         e = rxq.pop_front();
         `SBS_EQ(rxData, e)
         drive(4'h2, 4'h0, 8'h00);
      end
      `SBS_EQ(rxValid, 1'b0)
      // select pulled low under a controller with select as input
      drive(4'h8, 4'h0, 8'h50);
      tbSsn <= 1'b0;
      repeat (6) @(posedge core_clk);
      `SBS_EQ({serialControlReg[4], serialStatusReg[7]}, 2'h1)
      tbSsn <= 1'b1;
      complete_run;
   end
endmodule // tb
